// ---- hdl/acpi_wake_pkg.sv ----
// package: constants and carrier types of the sleep and wake logic
package acpi_wake_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_PM1_STS = 8'h00;
   localparam logic [7:0] OFS_PM1_EN = 8'h04;
   localparam logic [7:0] OFS_PM1_CTL = 8'h08;
   localparam logic [7:0] OFS_GPE_STS = 8'h0c;
   localparam logic [7:0] OFS_GPE_EN = 8'h10;
   localparam logic [7:0] OFS_GPIO_EDGE = 8'h14;
   localparam logic [7:0] OFS_PME_STS = 8'h18;
   localparam logic [7:0] OFS_PME_EN = 8'h1c;
   localparam logic [7:0] OFS_SMI_STS = 8'h20;
   localparam logic [7:0] OFS_SMI_EN = 8'h24;
   localparam logic [7:0] OFS_DSTATE = 8'h28;
   localparam logic [7:0] OFS_PWR_STATE = 8'h2c;
   localparam logic [7:0] OFS_POWER_SUPPLY_CONTROL = 8'hf8;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PM1_PRESS = 0;
   localparam int PM1_ALARM = 1;
   localparam int PM1_OVR = 2;
   localparam int PM1_POR = 3;
   localparam int CTL_SCI = 0;
   localparam int CTL_TYPE_LO = 2;
   localparam int CTL_SLP = 5;
   localparam int PSC_OFF = 0;
   localparam int PSC_SMI_SEL_N = 1;
   localparam int PSC_POR_WAKE = 2;
   localparam int PSC_POR_OFF = 3;
   localparam int PME_EN_GLOBAL = 16;
   localparam int SMI_EN_GLOBAL = 8;
   localparam int SMI_SLP = 7;
   localparam int GPE_N = 15;
   localparam int PME_N = 16;
   localparam int GPE_PME_ONLY_LO = 13;
   localparam int SMI_N = 8;
   localparam int FUNC_N = 8;
   localparam logic [15:0] PME_SRC_MASK = 16'h9fff;
   // ----------------------------------------
   // codes, reset values, timing
   // ----------------------------------------
   localparam logic [2:0] SLP_SOFT_OFF = 3'h7;
   localparam logic [2:0] SLP_SLEEPING = 3'h6;
   localparam logic [7:0] PSC_RST = 8'h00;
   localparam logic [10:0] GPIO_EDGE_RST = 11'h000;
   localparam int OVERRIDE_S = 4;
   localparam int CLK_HZ = 25_000_000;
   localparam int OVERRIDE_CYCLES = OVERRIDE_S * CLK_HZ;
   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef enum logic [1:0] {st_working, st_sleeping, st_soft_off} power_state_t;
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } av_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } av_rsp_t;
   typedef struct packed {
      logic ring_in1_n;
      logic kbd_line;
      logic mouse_line;
      logic special_key;
      logic [8:0] gpio_in;
      logic [1:0] gp_pme_in;
      logic fan_tach_event;
      logic alarm_event;
      logic button_in_n;
      logic standby_por;
      logic [6:0] legacy_irq;
   } wake_src_t;
   typedef struct packed {
      logic supply_on_n;
      logic pm_event_out_n;
      logic smi_out_n;
      logic [7:0] function_d3;
   } pwr_out_t;
endpackage : acpi_wake_pkg

// ---- hdl/acpi_sleep_wake_logic.sv ----
// module: sleep states, power button override and wake/pme/smi event logic
//
// Behaviour
// R1 - sleep write with code 111 enters soft-off
// R2 - sleep write with code 110 enters sleeping
// R3 - button or enabled wake returns to working
// R4 - button held past override forces soft-off
// R5 - override flag blocks all wakes but button
// R6 - wake drives supply low, pme drives pme low
// R7 - enabled pm1/gpe events wake unless overridden
// R8 - functions on/off only; wake stays available
// R9 - ring, keyboard, mouse edges set wake flags
// R10 - special key sets flag, may raise smi/pme
// R11 - gpio edges set flags; 34/35 pme only
// R12 - fan event reaches wake via any-pme only
// R13 - alarm and button flags: pme only, enabled
// R14 - standby por with wake enable wakes system
// R15 - standby por rewakes if previously powered on
// R16 - any-pme set only for pme-enabled events
// R17 - any pm1/gpe event may raise pme/smi/wake
// R18 - legacy interrupts raise smi, never wake
// R19 - wake configuration survives standby por
// R20 - short press flags on falling edge, wakes
// R21 - override clears press flag while setting override
// R22 - pme when sci route set, else smi route
// R23 - flags stick until cleared; contribution persists
//
// The Avalon-MM slave port is this design's own decision.
module acpi_sleep_wake_logic
   import acpi_wake_pkg::*;
#(
   parameter int OVR_CYCLES = OVERRIDE_CYCLES
)
(
   input wire logic clock,
   input wire logic reset,
   input wire av_req_t bus_req,
   output av_rsp_t bus_rsp,
   input wire wake_src_t src,
   output pwr_out_t pwr
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      power_state_t pstate;
      logic [31:0] hold_cnt;
      logic btn_prev;
      logic ring_prev;
      logic kbd_prev;
      logic mouse_prev;
      logic [10:0] gpio_prev;
      logic [3:0] pm1_sts;
      logic [1:0] pm1_en;
      logic [GPE_N-1:0] gpe_sts;
      logic [GPE_N-1:0] gpe_en;
      logic [10:0] gpio_edge;
      logic any_pme;
      logic [PME_N-1:0] pme_en;
      logic pme_global;
      logic [SMI_N-1:0] smi_sts;
      logic [SMI_N-1:0] smi_en;
      logic smi_global;
      logic sci_route_enable;
      logic [2:0] sleep_type;
      logic [7:0] psc;
      logic [FUNC_N-1:0] dstate;
      logic ack;
      logic [31:0] rdata;
      logic supply_n;
      logic pme_n;
      logic smi_n;
   } state_t;

   state_t state_ff;
   state_t nxt_state;

   logic [10:0] gpio_now;
   logic [10:0] gpio_ev;
   logic [GPE_N-1:0] gpe_ev;
   logic [PME_N-1:0] pme_src_ev;
   logic ring_ev;
   logic kbd_ev;
   logic mouse_ev;
   logic btn_fall;
   logic [GPE_N-1:0] gpe_act;
   logic press_act;
   logic alarm_act;
   logic smi_capable;
   logic pme_capable;
   logic wake;
   logic req_act;
   logic do_wr;
   logic [31:0] wmask;
   logic [31:0] wd;
   logic prior_on;
   logic por_wake;
   logic ovr_hit;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [31:0] m);
      return (old & ~m) | (d & m);
   endfunction : merge

   // ----------------------------------------
   // event detection
   // ----------------------------------------
   assign ring_ev = state_ff.ring_prev & ~src.ring_in1_n; // [R9]
   assign kbd_ev = state_ff.kbd_prev & ~src.kbd_line; // [R9]
   assign mouse_ev = state_ff.mouse_prev & ~src.mouse_line; // [R9]
   assign gpio_now = {src.gp_pme_in, src.gpio_in};
   // edge polarity per pin: 1 rising, 0 falling
   assign gpio_ev = (~state_ff.gpio_prev & gpio_now & state_ff.gpio_edge)
      | (state_ff.gpio_prev & ~gpio_now & ~state_ff.gpio_edge); // [R11]
   assign gpe_ev = {gpio_ev, src.special_key, mouse_ev, kbd_ev, ring_ev}; // [R10]
   // pme-only gpios never reach the any-pme flag
   assign pme_src_ev = {src.fan_tach_event, gpe_ev} & PME_SRC_MASK; // [R12] [R11]
   assign btn_fall = state_ff.btn_prev & ~src.button_in_n; // [R20]

   // ----------------------------------------
   // routing of enabled events
   // ----------------------------------------
   assign gpe_act = state_ff.gpe_sts & state_ff.gpe_en; // [R23]
   assign press_act = state_ff.pm1_sts[PM1_PRESS] & state_ff.pm1_en[PM1_PRESS]; // [R13]
   assign alarm_act = state_ff.pm1_sts[PM1_ALARM] & state_ff.pm1_en[PM1_ALARM]; // [R13]
   assign smi_capable = (|gpe_act[GPE_PME_ONLY_LO-1:0]) | state_ff.any_pme; // [R17]
   assign pme_capable = smi_capable | (|gpe_act[GPE_N-1:GPE_PME_ONLY_LO])
      | press_act | alarm_act; // [R17] [R13]
   // the press flag wakes regardless of its enable; override blocks the rest
   assign wake = state_ff.pm1_sts[PM1_PRESS]
      | (~state_ff.pm1_sts[PM1_OVR] & (pme_capable | state_ff.pm1_sts[PM1_POR])); // [R5] [R7]
   assign prior_on = (state_ff.pstate == st_working);
   assign por_wake = state_ff.psc[PSC_POR_WAKE] // [R14]
      | (prior_on & ~state_ff.psc[PSC_POR_OFF] & ~state_ff.psc[PSC_POR_WAKE]); // [R15]
   assign ovr_hit = ~src.button_in_n
      & (state_ff.hold_cnt == 32'(OVR_CYCLES - 1)); // [R4]

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   // one wait cycle per access keeps read data coming straight from a flop
   assign req_act = bus_req.read | bus_req.write;
   assign do_wr = bus_req.write & state_ff.ack;
   assign wd = bus_req.writedata;
   assign wmask = {{8{bus_req.byteenable[3]}}, {8{bus_req.byteenable[2]}},
                   {8{bus_req.byteenable[1]}}, {8{bus_req.byteenable[0]}}};
   assign bus_rsp.waitrequest = req_act & ~state_ff.ack;
   assign bus_rsp.readdata = state_ff.rdata;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.btn_prev = src.button_in_n;
      nxt_state.ring_prev = src.ring_in1_n;
      nxt_state.kbd_prev = src.kbd_line;
      nxt_state.mouse_prev = src.mouse_line;
      nxt_state.gpio_prev = gpio_now;
      nxt_state.ack = req_act & ~state_ff.ack;
      nxt_state.psc[PSC_OFF] = 1'b0;

      // read capture in the wait cycle
      if (req_act && !state_ff.ack)
      begin
         unique case (bus_req.address)
            OFS_PM1_STS: nxt_state.rdata = 32'(state_ff.pm1_sts);
            OFS_PM1_EN: nxt_state.rdata = 32'(state_ff.pm1_en);
            OFS_PM1_CTL: nxt_state.rdata = 32'({state_ff.sleep_type, 1'b0, state_ff.sci_route_enable});
            OFS_GPE_STS: nxt_state.rdata = 32'(state_ff.gpe_sts);
            OFS_GPE_EN: nxt_state.rdata = 32'(state_ff.gpe_en);
            OFS_GPIO_EDGE: nxt_state.rdata = 32'(state_ff.gpio_edge);
            OFS_PME_STS: nxt_state.rdata = 32'(state_ff.any_pme);
            OFS_PME_EN: nxt_state.rdata = 32'({state_ff.pme_global, state_ff.pme_en});
            OFS_SMI_STS: nxt_state.rdata = 32'(state_ff.smi_sts);
            OFS_SMI_EN: nxt_state.rdata = 32'({state_ff.smi_global, state_ff.smi_en});
            OFS_DSTATE: nxt_state.rdata = 32'(state_ff.dstate);
            OFS_PWR_STATE: nxt_state.rdata = 32'({state_ff.supply_n, state_ff.pstate});
            OFS_POWER_SUPPLY_CONTROL: nxt_state.rdata = 32'(state_ff.psc);
            default: nxt_state.rdata = 32'h0000_0000;
         endcase
      end

      // writes: clears first so that a same-cycle event set wins
      if (do_wr)
      begin
         unique case (bus_req.address)
            OFS_PM1_STS: nxt_state.pm1_sts = state_ff.pm1_sts & ~4'(wd & wmask); // [R23]
            OFS_PM1_EN: nxt_state.pm1_en = 2'(merge(32'(state_ff.pm1_en), wd, wmask));
            OFS_PM1_CTL:
            begin
               if (bus_req.byteenable[0])
               begin
                  nxt_state.sci_route_enable = wd[CTL_SCI];
                  nxt_state.sleep_type = wd[CTL_TYPE_LO+2:CTL_TYPE_LO];
               end
            end
            OFS_GPE_STS: nxt_state.gpe_sts = state_ff.gpe_sts & ~15'(wd & wmask); // [R23]
            OFS_GPE_EN: nxt_state.gpe_en = 15'(merge(32'(state_ff.gpe_en), wd, wmask));
            OFS_GPIO_EDGE:
               nxt_state.gpio_edge = 11'(merge(32'(state_ff.gpio_edge), wd, wmask));
            OFS_PME_STS: nxt_state.any_pme = state_ff.any_pme & ~(wd[0] & wmask[0]);
            OFS_PME_EN:
            begin
               nxt_state.pme_en = 16'(merge(32'(state_ff.pme_en), wd, wmask));
               if (bus_req.byteenable[2])
                  nxt_state.pme_global = wd[PME_EN_GLOBAL];
            end
            OFS_SMI_STS: nxt_state.smi_sts = state_ff.smi_sts & ~8'(wd & wmask);
            OFS_SMI_EN:
            begin
               nxt_state.smi_en = 8'(merge(32'(state_ff.smi_en), wd, wmask));
               if (bus_req.byteenable[1])
                  nxt_state.smi_global = wd[SMI_EN_GLOBAL];
            end
            OFS_DSTATE: nxt_state.dstate = 8'(merge(32'(state_ff.dstate), wd, wmask)); // [R8]
            OFS_POWER_SUPPLY_CONTROL:
               nxt_state.psc = 8'(merge(32'(state_ff.psc), wd, wmask));
            default: ;
         endcase
      end

      // status capture, sticky until software clears
      nxt_state.gpe_sts = nxt_state.gpe_sts | gpe_ev; // [R9] [R10] [R11]
      if (|(pme_src_ev & state_ff.pme_en))
         nxt_state.any_pme = 1'b1; // [R16] [R12]
      if (src.alarm_event)
         nxt_state.pm1_sts[PM1_ALARM] = 1'b1; // [R13]
      if (btn_fall)
         nxt_state.pm1_sts[PM1_PRESS] = 1'b1; // [R20]
      // legacy interrupts only ever land in the smi status
      nxt_state.smi_sts[SMI_SLP-1:0] = nxt_state.smi_sts[SMI_SLP-1:0] | src.legacy_irq; // [R18]

      // hold counter runs only while working with the button down
      if (state_ff.pstate == st_working && !src.button_in_n)
         nxt_state.hold_cnt = state_ff.hold_cnt + 32'h0000_0001;
      else
         nxt_state.hold_cnt = 32'h0000_0000;

      unique case (state_ff.pstate)
         st_working:
         begin
            if (ovr_hit)
            begin
               nxt_state.pstate = st_soft_off; // [R4]
               nxt_state.pm1_sts[PM1_OVR] = 1'b1; // [R4]
               nxt_state.pm1_sts[PM1_PRESS] = 1'b0; // [R21]
            end
            else if (do_wr && bus_req.address == OFS_PM1_CTL && bus_req.byteenable[0]
                     && wd[CTL_SLP])
            begin
               nxt_state.smi_sts[SMI_SLP] = 1'b1; // [R18]
               if (nxt_state.sleep_type == SLP_SOFT_OFF)
                  nxt_state.pstate = st_soft_off; // [R1]
               else if (nxt_state.sleep_type == SLP_SLEEPING)
                  nxt_state.pstate = st_sleeping; // [R2]
            end
            else if (state_ff.psc[PSC_OFF])
               nxt_state.pstate = st_soft_off;
         end
         st_sleeping, st_soft_off:
         begin
            if (wake)
               nxt_state.pstate = st_working; // [R3] [R7]
         end
      endcase

      // standby power-on: status restarts, configuration is kept
      if (src.standby_por)
      begin
         nxt_state.pstate = st_soft_off;
         nxt_state.hold_cnt = 32'h0000_0000;
         nxt_state.pm1_sts = 4'h0;
         nxt_state.gpe_sts = '0;
         nxt_state.any_pme = 1'b0;
         nxt_state.smi_sts = '0;
         nxt_state.pm1_sts[PM1_POR] = por_wake; // [R14] [R15] [R19]
      end

      // outputs; d-states never gate the wake path
      nxt_state.supply_n = (nxt_state.pstate != st_working); // [R6] [R8]
      nxt_state.pme_n = ~((state_ff.sci_route_enable & pme_capable) // [R22]
         | (state_ff.pme_global & state_ff.any_pme)); // [R6]
      nxt_state.smi_n = ~(state_ff.smi_global & ((~state_ff.sci_route_enable
         & ~state_ff.psc[PSC_SMI_SEL_N] & smi_capable) // [R22]
         | (|(state_ff.smi_sts & state_ff.smi_en)))); // [R18]
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state_ff <= '0;
         state_ff.pstate <= st_soft_off;
         state_ff.btn_prev <= 1'b1;
         state_ff.ring_prev <= 1'b1;
         state_ff.kbd_prev <= 1'b1;
         state_ff.mouse_prev <= 1'b1;
         state_ff.gpio_edge <= GPIO_EDGE_RST;
         state_ff.psc <= PSC_RST;
         state_ff.supply_n <= 1'b1;
         state_ff.pme_n <= 1'b1;
         state_ff.smi_n <= 1'b1;
      end
      else
         state_ff <= nxt_state;
   end

   assign pwr.supply_on_n = state_ff.supply_n;
   assign pwr.pm_event_out_n = state_ff.pme_n;
   assign pwr.smi_out_n = state_ff.smi_n;
   assign pwr.function_d3 = state_ff.dstate;
endmodule : acpi_sleep_wake_logic

// ---- tb/acpi_sleep_wake_logic_asserts.sv ----
// checker: port-level properties of the sleep and wake logic
module acpi_sleep_wake_logic_asserts
   import acpi_wake_pkg::*;
#(
   parameter int OVR_CYCLES = 20
)
(
   input wire logic clock,
   input wire logic reset,
   input wire av_req_t bus_req,
   input wire av_rsp_t bus_rsp,
   input wire wake_src_t src,
   input wire pwr_out_t pwr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] held_ff;
   logic done;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   assign done = (bus_req.read | bus_req.write) & ~bus_rsp.waitrequest;
   // button hold count, only while main power is on
   always_ff @(posedge clock)
   begin
      if (reset || src.button_in_n || pwr.supply_on_n)
         held_ff <= 32'h0;
      else
         held_ff <= held_ff + 32'h1;
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_one_wait;
      bus_rsp.waitrequest |=> !bus_rsp.waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait lasted over one cycle");
   property p_rewait;
      $rose(bus_req.read | bus_req.write) |-> bus_rsp.waitrequest;
   endproperty
   a_rewait: assert property (p_rewait) else $error("new access got no wait cycle");
   property p_unmapped;
      done && bus_req.read && (bus_req.address inside {[8'h30:8'hf4]})
         |-> bus_rsp.readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_sleep;
      done && bus_req.write && bus_req.address == OFS_PM1_CTL && bus_req.byteenable[0]
         && bus_req.writedata[5:3] == 3'h7 && !pwr.supply_on_n |=> pwr.supply_on_n;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep write kept power on");
   property p_ovr_bound;
      held_ff <= OVR_CYCLES + 3;
   endproperty
   a_ovr_bound: assert property (p_ovr_bound) else $error("long press kept power");
   property p_press_wake;
      $fell(src.button_in_n) && pwr.supply_on_n |-> ##[1:5] !pwr.supply_on_n;
   endproperty
   a_press_wake: assert property (p_press_wake) else $error("press did not wake");
   property p_dstate;
      done && bus_req.write && bus_req.address == OFS_DSTATE && bus_req.byteenable[0]
         |-> ##2 pwr.function_d3 == $past(bus_req.writedata[7:0], 2);
   endproperty
   a_dstate: assert property (p_dstate) else $error("function states wrong");
   // button still held after override: no other source may restore power
   property p_ovr_hold;
      $rose(pwr.supply_on_n) && !src.button_in_n |=> pwr.supply_on_n [*8];
   endproperty
   a_ovr_hold: assert property (p_ovr_hold) else $error("woke after override");
endmodule : acpi_sleep_wake_logic_asserts
bind acpi_sleep_wake_logic acpi_sleep_wake_logic_asserts #(.OVR_CYCLES(OVR_CYCLES))
   acpi_sleep_wake_logic_asserts_i (.clock(clock), .reset(reset), .bus_req(bus_req),
   .bus_rsp(bus_rsp), .src(src), .pwr(pwr));

// ---- tb/psu_model.sv ----
// partner: main supply that follows the supply-on request
module psu_model
#(
   parameter int RAMP = 3
)
(
   input wire logic clock,
   input wire logic supply_on_n,
   output logic main_ok
);
   timeunit 1ns;
   timeprecision 1ns;
   int ramp_cnt = 0;
   // rail settles slowly, drops at once
   always @(posedge clock)
   begin
      if (supply_on_n)
         ramp_cnt <= 0;
      else if (ramp_cnt < RAMP)
         ramp_cnt <= ramp_cnt + 1;
   end
   assign main_ok = (ramp_cnt == RAMP);
endmodule : psu_model

// ---- tb/tb_acpi_sleep_wake_logic.sv ----
// testbench: directed scenarios for the sleep and wake logic
`define CHK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp); \
      end \
   end
module tb_acpi_sleep_wake_logic
   import acpi_wake_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int OVR = 20;
   localparam wake_src_t IDLE = '{ring_in1_n: 1'b1, kbd_line: 1'b1, mouse_line: 1'b1,
      button_in_n: 1'b1, default: '0};
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic main_ok;
   av_req_t req = '0;
   av_rsp_t rsp;
   wake_src_t src = IDLE;
   wake_src_t m = '0;
   pwr_out_t pwr;
   logic [31:0] q;
   int n_mismatch = 0;
   int samples_checked = 0;
   always #20 clock = ~clock;
   acpi_sleep_wake_logic #(.OVR_CYCLES(OVR)) acpi_sleep_wake_logic_i (.clock(clock),
      .reset(reset), .bus_req(req), .bus_rsp(rsp), .src(src), .pwr(pwr));
   psu_model #(.RAMP(3)) psu_model_i (.clock(clock), .supply_on_n(pwr.supply_on_n),
      .main_ok(main_ok));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic end_sim;
      $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic neg(input int n);
      repeat (n) @(negedge clock);
   endtask : neg
   // request held from a rising edge until waitrequest is low at one
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
      @(posedge clock);
      while (rsp.waitrequest)
         @(posedge clock);
      q = rsp.readdata;
      req <= '0;
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rd
   task automatic sup(input logic lvl);
      @(negedge clock);
      for (int i = 0; i < 10 && pwr.supply_on_n !== lvl; i++)
         @(negedge clock);
      `CHK(pwr.supply_on_n, lvl)
   endtask : sup
   task automatic press(input int n);
      @(posedge clock);
      src.button_in_n <= 1'b0;
      repeat (n) @(posedge clock);
      src.button_in_n <= 1'b1;
   endtask : press
   // toggles the lines in m for one cycle: idle-high lines fall, pulses rise
   task automatic pulse;
      @(posedge clock);
      src <= wake_src_t'(src ^ m);
      @(posedge clock);
      src <= wake_src_t'(src ^ m);
   endtask : pulse
   task automatic wake;
      press(2);
      sup(1'b0);
      wr(OFS_PM1_STS, 32'hf);
   endtask : wake
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic s_regs;
      rd(OFS_POWER_SUPPLY_CONTROL, {24'h0, PSC_RST});
      rd(OFS_PWR_STATE, 32'h6);
      wr(OFS_DSTATE, 32'ha5);
      neg(3);
      `CHK(pwr.function_d3, 8'ha5)
      wr(8'h40, 32'hffffffff);
      rd(8'h40, 32'h0);
      wr(OFS_DSTATE, 32'h0);
   endtask : s_regs
   task automatic s_press;
      press(2);
      sup(1'b0);
      neg(4);
      `CHK(main_ok, 1'b1)
      rd(OFS_PM1_STS, 32'h1);
      wr(OFS_PM1_STS, 32'hf);
      rd(OFS_PWR_STATE, 32'h0);
   endtask : s_press
   task automatic s_sleep;
      for (int k = 0; k < 2; k++)
      begin
         wr(OFS_PM1_CTL, {26'h0, 1'b1, k ? SLP_SLEEPING : SLP_SOFT_OFF, 2'h0});
         sup(1'b1);
         rd(OFS_PWR_STATE, {29'h0, 1'b1, k ? 2'h1 : 2'h2});
         rd(OFS_SMI_STS, 32'h80);
         wr(OFS_SMI_STS, 32'hff);
         wake;
      end
   endtask : s_sleep
   task automatic s_gpe;
      wr(OFS_GPE_EN, 32'h2);
      wr(OFS_PM1_EN, 32'h2);
      wr(OFS_PM1_CTL, 32'h3d);
      sup(1'b1);
      m = '0;
      m.kbd_line = 1'b1;
      pulse;
      sup(1'b0);
      `CHK(pwr.pm_event_out_n, 1'b0)
      rd(OFS_GPE_STS, 32'h2);
      rd(OFS_PME_STS, 32'h0);
      wr(OFS_GPE_STS, 32'h7fff);
      neg(2);
      `CHK(pwr.pm_event_out_n, 1'b1)
      wr(OFS_PM1_CTL, 32'h39);
      sup(1'b1);
      m = '0;
      m.alarm_event = 1'b1;
      pulse;
      sup(1'b0);
      rd(OFS_PM1_STS, 32'h2);
      wr(OFS_PM1_STS, 32'hf);
   endtask : s_gpe
   task automatic s_legacy;
      wr(OFS_SMI_EN, 32'h101);
      wr(OFS_PM1_CTL, 32'h3c);
      sup(1'b1);
      @(posedge clock);
      src.legacy_irq <= 7'h01;
      neg(4);
      `CHK(pwr.smi_out_n, 1'b0)
      `CHK(pwr.supply_on_n, 1'b1)
      @(posedge clock);
      src.legacy_irq <= 7'h00;
      wr(OFS_SMI_STS, 32'hff);
      // sci routing off: an enabled gpe event wakes and raises smi, not pme
      m = '0;
      m.kbd_line = 1'b1;
      pulse;
      sup(1'b0);
      `CHK(pwr.smi_out_n, 1'b0)
      `CHK(pwr.pm_event_out_n, 1'b1)
      wr(OFS_GPE_STS, 32'h7fff);
      wr(OFS_SMI_EN, 32'h0);
   endtask : s_legacy
   task automatic s_special;
      wr(OFS_PME_EN, 32'h18008);
      m = '0;
      m.special_key = 1'b1;
      pulse;
      neg(4);
      `CHK(pwr.pm_event_out_n, 1'b0)
      rd(OFS_GPE_STS, 32'h8);
      wr(OFS_GPE_STS, 32'h7fff);
      wr(OFS_PME_STS, 32'h1);
      m = '0;
      m.fan_tach_event = 1'b1;
      pulse;
      neg(4);
      rd(OFS_PME_STS, 32'h1);
      rd(OFS_GPE_STS, 32'h0);
      wr(OFS_PME_STS, 32'h1);
      // gpio 23 on a rising edge, gpio 34 on a falling edge; 34 never reaches any-pme
      wr(OFS_PME_EN, 32'h2000);
      wr(OFS_GPIO_EDGE, 32'h1);
      m = '0;
      m.gpio_in[0] = 1'b1;
      m.gp_pme_in[0] = 1'b1;
      pulse;
      rd(OFS_GPE_STS, 32'h2010);
      rd(OFS_PME_STS, 32'h0);
      wr(OFS_GPE_STS, 32'h7fff);
      wr(OFS_GPIO_EDGE, 32'h0);
      wr(OFS_PME_EN, 32'h0);
   endtask : s_special
   task automatic s_override;
      press(OVR + 4);
      sup(1'b1);
      rd(OFS_PM1_STS, 32'h4);
      m = '0;
      m.kbd_line = 1'b1;
      pulse;
      neg(6);
      `CHK(pwr.supply_on_n, 1'b1)
      wake;
      wr(OFS_GPE_STS, 32'h7fff);
   endtask : s_override
   // standby power return: config kept, wake decided by the supply control bits
   task automatic s_por;
      logic [7:0] psc [3] = '{8'h04, 8'h00, 8'h08};
      logic off_n [3] = '{1'b0, 1'b0, 1'b1};
      for (int k = 0; k < 3; k++)
      begin
         wr(OFS_POWER_SUPPLY_CONTROL, {24'h0, psc[k]});
         m = '0;
         m.standby_por = 1'b1;
         pulse;
         neg(6);
         `CHK(pwr.supply_on_n, off_n[k])
         rd(OFS_PM1_STS, {28'h0, !off_n[k], 3'h0});
         rd(OFS_GPE_EN, 32'h2);
         rd(OFS_POWER_SUPPLY_CONTROL, {24'h0, psc[k]});
         wr(OFS_PM1_STS, 32'hf);
      end
   endtask : s_por
   initial
   begin
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      s_regs;
      s_press;
      s_sleep;
      s_gpe;
      s_legacy;
      s_special;
      s_override;
      s_por;
      end_sim;
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      end_sim;
   end
endmodule : tb_acpi_sleep_wake_logic
